// >>> core/sab_engine.sv
// Serial port autobuffer engine.
// Summary of operation
// - Plain mode: interrupt once per word.
// - Each receive word steals one cycle; a transmit word steals until the memory read answers.
// - Multichannel: move only enabled channel words.
// - Moves target data memory only.
// - No per-word interrupt for autobuffered words.
// - Store or load at index, then post-modify.
// - Modify register shares generator with index.
// - Stolen cycle waits for instruction completion.
// - Move during idle leaves processor idle.
// - Interrupt when index wraps the buffer.
// - Receive wrap interrupt after last word stored.
// - Transmit wrap interrupt when last word loaded.
// - Moves outrank all but host/byte cycles.
// - Priority: p0 tx, p0 rx, p1 tx, p1 rx.
// - Separate tx/rx enables per control register.
// - Reset and reboot clear both enables.
// - Overlaid moves use current overlay page.
// - Disabled slots: no data, interrupt, move.
`timescale 1ns/1ps
module sab_engine import sab_pkg::*; #(
    parameter int AW    = ADDR_W,
    parameter int DW    = DATA_W,
    parameter int PW    = PAGE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic          SYS_CLK,
    input  wire logic          SRST,
    input  wire logic          CE,
    input  wire logic          REBOOT,
    input  wire logic [13:0]   REG_ADDR,
    input  wire logic [15:0]   REG_WDATA,
    input  wire logic          REG_WR,
    input  wire logic          REG_RD,
    output logic      [15:0]   REG_RDATA,
    input  wire logic [1:0]    RX_WORD_VALID,
    input  wire logic [1:0]    RX_SLOT_EN,
    input  wire logic [DW-1:0] RX_DATA_P0,
    input  wire logic [DW-1:0] RX_DATA_P1,
    input  wire logic [1:0]    TX_REG_FREE,
    input  wire logic [1:0]    TX_SLOT_EN,
    output logic      [1:0]    TX_LOAD,
    output logic      [DW-1:0] TX_LOAD_DATA,
    output logic      [1:0]    IRQ_TX,
    output logic      [1:0]    IRQ_RX,
    input  wire logic          INSTR_DONE,
    input  wire logic          CORE_IDLE,
    input  wire logic          HOST_DMA_CYCLE,
    input  wire logic          BYTE_DMA_CYCLE,
    output logic               STEAL,
    output logic      [2:0]    DAG_I_SEL,
    output logic      [2:0]    DAG_M_SEL,
    input  wire logic [AW-1:0] DAG_I,
    input  wire logic [AW-1:0] DAG_M,
    input  wire logic [AW-1:0] DAG_L,
    input  wire logic [AW-1:0] DAG_B,
    output logic               DAG_I_WE,
    output logic      [AW-1:0] DAG_I_NEW,
    input  wire logic [PW-1:0] OVL_PAGE,
    output logic               DM_RD,
    output logic      [AW-1:0] DM_ADDR,
    output logic      [PW-1:0] DM_PAGE,
    input  wire logic [DW-1:0] DM_RDATA,
    input  wire logic          DM_RD_ACK,
    output logic               DM_WR_VALID,
    input  wire logic          DM_WR_READY,
    output logic      [AW-1:0] DM_WR_ADDR,
    output logic      [DW-1:0] DM_WR_DATA,
    output logic      [PW-1:0] DM_WR_PAGE
);

    localparam int FW = PW + AW + DW;

    typedef struct packed {
        eng_state_t          st;
        logic [1:0][15:0]    ctrl;
        logic [3:0]          pend;
        logic [1:0][DW-1:0]  rxd;
        logic [1:0]          ch;
        logic                selv;
        logic [2:0]          isel;
        logic [2:0]          msel;
        logic                steal;
        logic                iwe;
        logic [AW-1:0]       inew;
        logic                wrap;
        logic                dmrd;
        logic [AW-1:0]       dmaddr;
        logic [PW-1:0]       dmpage;
        logic [1:0]          txload;
        logic [DW-1:0]       txdata;
        logic [3:0]          irq;
        logic [1:0]          rxirq_wait;
        logic [15:0]         rdata;
    } eng_t;

    eng_t            st_reg;
    eng_t            st_next;
    logic [AW-1:0]   wc_new;
    logic            wc_wrap;
    logic            f_push;
    logic            f_ready;
    logic            f_empty;
    logic [FW-1:0]   f_out;
    logic [FW-1:0]   f_in;
    logic [PW-1:0]   cur_page;
    logic [1:0][DW-1:0] rx_word;

    assign rx_word[0] = RX_DATA_P0;
    assign rx_word[1] = RX_DATA_P1;

    // Overlaid window uses the page selected at the move.
    assign cur_page = (DAG_I <= AW'(OVERLAY_LIMIT)) ? OVL_PAGE : '0;
    assign f_in     = {cur_page, DAG_I, st_reg.rxd[st_reg.ch[1]]};

    // Post-modify of the selected index.
    sab_wrap #(.AW(AW)) u_wrap (
        .idx     (DAG_I),
        .modv    (DAG_M),
        .len     (DAG_L),
        .base    (DAG_B),
        .new_idx (wc_new),
        .wrapped (wc_wrap)
    );

    // Received words queue here so memory wait states do not stall the port;
    // a full queue holds off the next receive move instead.
    sab_fifo #(.W(FW), .D(DEPTH)) u_fifo (
        .clk       (SYS_CLK),
        .srst      (SRST),
        .ce        (CE),
        .in_valid  (f_push),
        .in_ready  (f_ready),
        .in_data   (f_in),
        .out_valid (DM_WR_VALID),
        .out_ready (DM_WR_READY),
        .out_data  (f_out),
        .empty     (f_empty)
    );

    assign DM_WR_PAGE = f_out[FW-1 -: PW];
    assign DM_WR_ADDR = f_out[DW +: AW];
    assign DM_WR_DATA = f_out[DW-1:0];

    // All outputs but the data memory write port, which comes from the queue, come from the state register.
    assign REG_RDATA    = st_reg.rdata;
    assign TX_LOAD      = st_reg.txload;
    assign TX_LOAD_DATA = st_reg.txdata;
    assign IRQ_TX       = {st_reg.irq[2], st_reg.irq[0]};
    assign IRQ_RX       = {st_reg.irq[3], st_reg.irq[1]};
    assign STEAL        = st_reg.steal;
    assign DAG_I_SEL    = st_reg.isel;
    assign DAG_M_SEL    = st_reg.msel;
    assign DAG_I_WE     = st_reg.iwe;
    assign DAG_I_NEW    = st_reg.inew;
    assign DM_RD        = st_reg.dmrd;
    assign DM_ADDR      = st_reg.dmaddr;
    assign DM_PAGE      = st_reg.dmpage;

    // Next state: registers, arbitration, moves, events.
    always_comb begin
        logic [1:0]  pick;
        logic        any;
        logic        gate;
        logic [15:0] cr;
        pick    = 2'd0;
        any     = |st_reg.pend;
        gate    = 1'b0;
        cr      = '0;
        f_push  = 1'b0;
        st_next = st_reg;
        st_next.iwe    = 1'b0;
        st_next.dmrd   = 1'b0;
        st_next.txload = '0;
        st_next.irq    = '0;

        // Lowest channel number wins.
        for (int c = 3; c >= 0; c--) begin
            if (st_reg.pend[c]) begin
                pick = c[1:0];
            end
        end
        cr = st_reg.ctrl[pick[1]];

        // Control registers; a write drops any preselected index pair.
        if (REG_WR && REG_ADDR == P0_CTRL_ADDR) begin
            st_next.ctrl[0] = REG_WDATA & CTRL_MASK;
            st_next.selv = 1'b0;
        end
        if (REG_WR && REG_ADDR == P1_CTRL_ADDR) begin
            st_next.ctrl[1] = REG_WDATA & CTRL_MASK;
            st_next.selv = 1'b0;
        end
        if (REG_RD) begin
            st_next.rdata = (REG_ADDR == P0_CTRL_ADDR) ? st_reg.ctrl[0] :
                            (REG_ADDR == P1_CTRL_ADDR) ? st_reg.ctrl[1] : 16'h0000;
        end

        case (st_reg.st)
            ST_IDLE: begin
                // Select the pair one cycle ahead so a receive move itself takes one cycle.
                st_next.ch   = pick;
                st_next.selv = any && (!REG_WR || st_next.selv);
                st_next.isel = pick[0] ? cr[RX_IDX_LSB +: 3] : cr[TX_IDX_LSB +: 3];
                st_next.msel = {st_next.isel[2], pick[0] ? cr[RX_MOD_LSB +: 2] : cr[TX_MOD_LSB +: 2]};
                // Only at an instruction boundary or in idle, never over DMA cycles.
                gate = (INSTR_DONE || CORE_IDLE) && !HOST_DMA_CYCLE && !BYTE_DMA_CYCLE;
                if (st_reg.selv && any && st_reg.ch == pick && gate && (pick[0] ? f_ready : f_empty)) begin
                    st_next.st     = ST_MOVE;
                    st_next.steal  = 1'b1;
                    st_next.iwe    = 1'b1;
                    st_next.inew   = wc_new;
                    st_next.wrap   = wc_wrap;
                    st_next.dmaddr = DAG_I;
                    st_next.dmpage = cur_page;
                    st_next.dmrd   = !pick[0];
                    f_push         = pick[0];
                    st_next.pend[pick] = 1'b0;
                    st_next.selv   = 1'b0;
                end
            end
            ST_MOVE: begin
                // Receive finishes at once; transmit waits out memory wait states.
                if (st_reg.ch[0] || DM_RD_ACK) begin
                    st_next.st    = ST_IDLE;
                    st_next.steal = 1'b0;
                    if (!st_reg.ch[0]) begin
                        st_next.txload[st_reg.ch[1]] = 1'b1;
                        st_next.txdata = DM_RDATA;
                        st_next.irq[st_reg.ch] = st_reg.wrap;
                    end else if (st_reg.wrap) begin
                        st_next.rxirq_wait[st_reg.ch[1]] = 1'b1;
                    end
                end
            end
            default: begin
                st_next.st    = ST_IDLE;
                st_next.steal = 1'b0;
            end
        endcase

        // Receive wrap is reported once the queue has drained.
        for (int p = 0; p < 2; p++) begin
            if (st_reg.rxirq_wait[p] && f_empty) begin
                st_next.irq[2*p+1] = 1'b1;
                st_next.rxirq_wait[p] = 1'b0;
            end
        end

        // Port events; a new request beats a clear in the same cycle.
        for (int p = 0; p < 2; p++) begin
            if (RX_WORD_VALID[p] && RX_SLOT_EN[p]) begin
                if (st_reg.ctrl[p][RX_ENABLE_BIT]) begin
                    st_next.pend[2*p+1] = 1'b1;
                    st_next.rxd[p] = rx_word[p];
                end else begin
                    st_next.irq[2*p+1] = 1'b1;
                end
            end
            if (TX_REG_FREE[p] && TX_SLOT_EN[p]) begin
                if (st_reg.ctrl[p][TX_ENABLE_BIT]) begin
                    st_next.pend[2*p] = 1'b1;
                end else begin
                    st_next.irq[2*p] = 1'b1;
                end
            end
        end

        // Reboot clears enables and abandons moves in flight.
        if (REBOOT) begin
            for (int p = 0; p < 2; p++) begin
                st_next.ctrl[p][RX_ENABLE_BIT] = 1'b0;
                st_next.ctrl[p][TX_ENABLE_BIT] = 1'b0;
            end
            st_next.pend       = '0;
            st_next.st         = ST_IDLE;
            st_next.steal      = 1'b0;
            st_next.selv       = 1'b0;
            st_next.rxirq_wait = '0;
        end
    end

    // Reset clears controls and idles the engine.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            st_reg <= '0;
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST || !CE);

    chk_rx_one_cycle: assert property ($rose(STEAL) && st_reg.ch[0] |=> !STEAL)
        else $error("receive move stole more than one cycle");
    chk_boundary_wait: assert property ($rose(STEAL) |-> $past(INSTR_DONE || CORE_IDLE))
        else $error("move started inside an instruction");
    chk_dma_yield: assert property ($rose(STEAL) |-> !$past(HOST_DMA_CYCLE) && !$past(BYTE_DMA_CYCLE))
        else $error("move started over a DMA cycle");
    chk_priority_order: assert property ($rose(STEAL) |-> ($past(st_reg.pend) & ((4'h1 << st_reg.ch) - 4'h1)) == 4'h0)
        else $error("lower priority request served first");
    chk_pair_generator: assert property (DAG_M_SEL[2] == DAG_I_SEL[2])
        else $error("index and modify in different generators");
    chk_index_update: assert property ($rose(STEAL) |-> DAG_I_WE && DM_ADDR == $past(DAG_I))
        else $error("move did not use and update the index");
    chk_reboot_clear: assert property (REBOOT |=> st_reg.ctrl[0][1:0] == 2'b00 && st_reg.ctrl[1][1:0] == 2'b00 && !STEAL)
        else $error("reboot left autobuffering enabled");
    chk_plain_irq: assert property (RX_WORD_VALID[0] && RX_SLOT_EN[0] && !st_reg.ctrl[0][0] && !REBOOT |=> IRQ_RX[0])
        else $error("missing per-word receive interrupt");
    chk_slot_skip: assert property (RX_WORD_VALID[1] && !RX_SLOT_EN[1] && !st_reg.pend[3] |=> !st_reg.pend[3])
        else $error("disabled slot raised a move");
    chk_tx_request: assert property (TX_REG_FREE[0] && TX_SLOT_EN[0] && st_reg.ctrl[0][1] && !REBOOT |=> st_reg.pend[0])
        else $error("transmit request lost");
    chk_tx_wrap_irq: assert property (IRQ_TX[0] && !$past(TX_REG_FREE[0]) |-> TX_LOAD[0])
        else $error("transmit wrap interrupt without load");

    cov_rx_move: cover property ($rose(STEAL) && st_reg.ch == 2'd1);
    cov_tx_move: cover property ($rose(STEAL) && st_reg.ch == 2'd2 ##[1:20] TX_LOAD[1]);
    cov_all_pending: cover property (st_reg.pend == 4'hf);
    cov_rx_wrap: cover property (IRQ_RX[0] && st_reg.ctrl[0][0]);

endmodule

// >>> core/sab_fifo.sv
// Parameterised FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module sab_fifo #(
    parameter int W = 34,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data,
    output logic              empty
);

    localparam int PW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
        logic [PW:0]         cnt;
    } fifo_t;

    fifo_t st_reg;
    fifo_t st_next;
    logic  push;
    logic  pop;

    // Full and empty come from the count, so they never lie.
    assign in_ready  = (st_reg.cnt != (PW+1)'(D));
    assign empty     = (st_reg.cnt == '0);
    assign out_valid = !empty;
    assign out_data  = st_reg.mem[st_reg.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Explicit wrap keeps any depth legal.
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = (st_reg.wp == PW'(D-1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == PW'(D-1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

endmodule

// >>> core/sab_pkg.sv
// Constants and types of the autobuffer engine.
package sab_pkg;

    // Register addresses of the two autobuffer control registers.
    localparam logic [13:0] P0_CTRL_ADDR = 14'h3ff3;
    localparam logic [13:0] P1_CTRL_ADDR = 14'h3fef;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] CTRL_MASK    = 16'h0fff;

    // Field positions inside an autobuffer control register.
    localparam int RX_ENABLE_BIT = 0;
    localparam int TX_ENABLE_BIT = 1;
    localparam int RX_MOD_LSB    = 2;
    localparam int RX_IDX_LSB    = 4;
    localparam int TX_MOD_LSB    = 7;
    localparam int TX_IDX_LSB    = 9;

    // Upper end of the overlaid data memory window.
    localparam logic [13:0] OVERLAY_LIMIT = 14'h1fff;

    // Default widths and depths.
    localparam int ADDR_W     = 14;
    localparam int DATA_W     = 16;
    localparam int PAGE_W     = 4;
    localparam int FIFO_DEPTH = 16;

    // Engine states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MOVE = 2'b01
    } eng_state_t;

endpackage

// >>> core/sab_wrap.sv
// Circular post-modify of an index with wrap detection.
`timescale 1ns/1ps
module sab_wrap #(
    parameter int AW = 14
) (
    input  wire logic [AW-1:0] idx,
    input  wire logic [AW-1:0] modv,
    input  wire logic [AW-1:0] len,
    input  wire logic [AW-1:0] base,
    output logic      [AW-1:0] new_idx,
    output logic               wrapped
);

    logic signed [AW+1:0] sum;
    logic signed [AW+1:0] lo;
    logic signed [AW+1:0] hi;

    // Modify is signed; a zero length means linear addressing with no wrap.
    always_comb begin
        sum     = $signed({2'b00, idx}) + $signed({{2{modv[AW-1]}}, modv});
        lo      = $signed({2'b00, base});
        hi      = $signed({2'b00, base}) + $signed({2'b00, len});
        new_idx = sum[AW-1:0];
        wrapped = 1'b0;
        if (len != '0) begin
            if (sum >= hi) begin
                new_idx = AW'(sum - $signed({2'b00, len}));
                wrapped = 1'b1;
            end else if (sum < lo) begin
                new_idx = AW'(sum + $signed({2'b00, len}));
                wrapped = 1'b1;
            end
        end
    end

endmodule

// >>> dv/sab_cpu.sv
// Processor core model: address generators and data memory.
`timescale 1ns/1ps
module sab_cpu (
    input  wire logic        clk,
    input  wire logic [2:0]  i_sel,
    input  wire logic [2:0]  m_sel,
    input  wire logic        i_we,
    input  wire logic [13:0] i_new,
    output logic      [13:0] dag_i,
    output logic      [13:0] dag_m,
    output logic      [13:0] dag_l,
    output logic      [13:0] dag_b,
    input  wire logic        rd,
    input  wire logic [13:0] rd_addr,
    output logic      [15:0] rdata,
    output logic             ack,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [13:0] wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [3:0]  wr_page,
    input  wire logic        stall,
    input  wire logic [3:0]  ack_dly
);
    // Every modify register steps by one.
    logic [13:0] ireg [8] = '{default: 14'h0000};
    logic [13:0] mreg [8] = '{default: 14'h0001};
    logic [13:0] lreg [8] = '{default: 14'h0040};
    logic [13:0] breg [8] = '{default: 14'h0000};
    logic [15:0] mem [64] = '{default: 16'h0000};
    logic [13:0] a_q;
    logic [3:0]  cnt = 4'h0;
    logic [3:0]  last_page;
    int          n_wr = 0;

    // Start-up values of the read bus.
    initial begin
        rdata = 16'h5a5a;
        ack = 1'b0;
    end

    // Same-cycle lookup of the selected registers.
    assign dag_i = ireg[i_sel];
    assign dag_m = mreg[m_sel];
    assign dag_l = lreg[i_sel];
    assign dag_b = breg[i_sel];
    // A stalled memory refuses writes.
    assign wr_ready = !stall;

    // Data memory only; read data toggle while no answer is due.
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (i_we) begin
            ireg[i_sel] <= i_new;
        end
        if (wr_valid && wr_ready) begin
            mem[wr_addr[5:0]] <= wr_data;
            last_page <= wr_page;
            n_wr++;
        end
        if (rd) begin
            a_q <= rd_addr;
            cnt <= ack_dly;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                ack <= 1'b1;
                rdata <= mem[a_q[5:0]];
            end
        end
    end
endmodule

// >>> dv/sab_engine_tb.sv
// Self-checking bench for the autobuffer engine.
`timescale 1ns/1ps
module sab_engine_tb import sab_pkg::*;;
    logic        SYS_CLK = 1'b0;
    logic        SRST = 1'b1;
    logic        CE = 1'b1;
    logic        REBOOT = 1'b0;
    logic [13:0] REG_ADDR = 14'h0000;
    logic [15:0] REG_WDATA = 16'h0000;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic [1:0]  RX_WORD_VALID = 2'h0;
    logic [1:0]  RX_SLOT_EN = 2'h3;
    logic [15:0] RX_DATA_P0 = 16'h0000;
    logic [15:0] RX_DATA_P1 = 16'h0000;
    logic [1:0]  TX_REG_FREE = 2'h0;
    logic [1:0]  TX_SLOT_EN = 2'h3;
    logic        INSTR_DONE = 1'b1;
    logic        CORE_IDLE = 1'b0;
    logic        HOST_DMA_CYCLE = 1'b0;
    logic        BYTE_DMA_CYCLE = 1'b0;
    logic [3:0]  OVL_PAGE = 4'h3;
    logic [15:0] REG_RDATA, TX_LOAD_DATA, DM_RDATA, DM_WR_DATA;
    logic [1:0]  TX_LOAD, IRQ_TX, IRQ_RX;
    logic        STEAL, DAG_I_WE, DM_RD, DM_RD_ACK, DM_WR_VALID, DM_WR_READY;
    logic [2:0]  DAG_I_SEL, DAG_M_SEL;
    logic [13:0] DAG_I, DAG_M, DAG_L, DAG_B, DAG_I_NEW, DM_ADDR, DM_WR_ADDR;
    logic [3:0]  DM_PAGE, DM_WR_PAGE;
    logic        stall = 1'b0;
    logic [3:0]  ack_dly = 4'h1;
    int          n_errors = 0, n_tests = 0, n_steal = 0, n_bad = 0;
    int          n_irx [2] = '{0, 0};
    int          n_itx [2] = '{0, 0};
    logic [5:0]  sel_q [$];
    logic [15:0] load_q [$];

    always #2 SYS_CLK = ~SYS_CLK;

    sab_engine u_sab_engine (.*);
    sab_cpu u_sab_cpu (
        .clk(SYS_CLK), .i_sel(DAG_I_SEL), .m_sel(DAG_M_SEL), .i_we(DAG_I_WE), .i_new(DAG_I_NEW),
        .dag_i(DAG_I), .dag_m(DAG_M), .dag_l(DAG_L), .dag_b(DAG_B), .rd(DM_RD), .rd_addr(DM_ADDR),
        .rdata(DM_RDATA), .ack(DM_RD_ACK), .wr_valid(DM_WR_VALID), .wr_ready(DM_WR_READY),
        .wr_addr(DM_WR_ADDR), .wr_data(DM_WR_DATA), .wr_page(DM_WR_PAGE), .stall(stall), .ack_dly(ack_dly)
    );

    // Log at the falling edge, away from the edge that launches the outputs.
    always @(negedge SYS_CLK) begin
        if (!SRST) begin
            if (DAG_I_WE) sel_q.push_back({DAG_I_SEL, DAG_M_SEL});
            if (TX_LOAD != 2'h0) load_q.push_back(TX_LOAD_DATA);
            if (STEAL === 1'b1) n_steal++;
            if ((IRQ_TX & ~TX_LOAD) != 2'h0) n_bad++;
            for (int p = 0; p < 2; p++) begin
                n_irx[p] += int'(IRQ_RX[p] === 1'b1);
                n_itx[p] += int'(IRQ_TX[p] === 1'b1);
            end
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask

    // One register access; read data stand from the edge after the read strobe.
    task automatic reg_op(input logic [13:0] a, input logic [15:0] d, input logic w);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = w;
        REG_RD = !w;
        cyc(1);
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        cyc(1);
    endtask

    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        reg_op(a, d, 1'b1);
    endtask

    task automatic rd_chk(input logic [13:0] a, input logic [15:0] e);
        reg_op(a, 16'h0000, 1'b0);
        chk(REG_RDATA, e);
    endtask

    task automatic rx_word(input int p, input logic [15:0] d);
        RX_DATA_P0 = d;
        RX_DATA_P1 = d;
        RX_WORD_VALID[p] = 1'b1;
        cyc(1);
        RX_WORD_VALID = 2'h0;
    endtask

    task automatic tx_free(input int p);
        TX_REG_FREE[p] = 1'b1;
        cyc(1);
        TX_REG_FREE = 2'h0;
    endtask

    task automatic address_generator(input int r, input logic [13:0] b, input logic [13:0] l);
        u_sab_cpu.ireg[r] = b;
        u_sab_cpu.breg[r] = b;
        u_sab_cpu.lreg[r] = l;
    endtask

    // Wait for n more index write-backs, then drain.
    task automatic wait_moves(input int n);
        int k;
        k = sel_q.size();
        for (int i = 0; i < 200 && sel_q.size() < k + n; i++) cyc(1);
        cyc(8);
    endtask

    task automatic t_regs;
        rd_chk(P0_CTRL_ADDR, CTRL_RESET);
        rd_chk(P1_CTRL_ADDR, CTRL_RESET);
        wr(P1_CTRL_ADDR, 16'hf013);
        rd_chk(P1_CTRL_ADDR, 16'h0013);
        rd_chk(P0_CTRL_ADDR, 16'h0000);
        wr(14'h3ff0, 16'h0fff);
        rd_chk(14'h3ff0, 16'h0000);
        wr(P1_CTRL_ADDR, 16'h0000);
        $display("test regs done");
    endtask

    // Plain words interrupt once each; disabled slots do nothing.
    task automatic t_plain;
        rx_word(0, 16'h1111);
        tx_free(1);
        cyc(4);
        chk(16'(n_irx[0]), 16'h0001);
        chk(16'(n_itx[1]), 16'h0001);
        wr(P0_CTRL_ADDR, 16'h0017);
        RX_SLOT_EN = 2'h0;
        TX_SLOT_EN = 2'h0;
        rx_word(0, 16'h2222);
        tx_free(0);
        cyc(8);
        chk(16'(n_irx[0] + n_itx[0]), 16'h0001);
        chk(16'(n_steal), 16'h0000);
        RX_SLOT_EN = 2'h3;
        TX_SLOT_EN = 2'h3;
        wr(P0_CTRL_ADDR, 16'h0000);
        $display("test plain done");
    endtask

    // Two-word receive buffer; first move in idle.
    task automatic t_rx;
        int s;
        address_generator(1, 14'h0010, 14'h0002);
        wr(P1_CTRL_ADDR, 16'h0015);
        INSTR_DONE = 1'b0;
        CORE_IDLE = 1'b1;
        s = n_steal;
        rx_word(1, 16'haaa1);
        wait_moves(1);
        chk(16'(n_steal - s), 16'h0001);
        chk(u_sab_cpu.mem[16], 16'haaa1);
        chk({2'h0, u_sab_cpu.ireg[1]}, 16'h0011);
        chk(16'(n_irx[1]), 16'h0000);
        INSTR_DONE = 1'b1;
        CORE_IDLE = 1'b0;
        rx_word(1, 16'haaa2);
        wait_moves(1);
        chk(u_sab_cpu.mem[17], 16'haaa2);
        chk({2'h0, u_sab_cpu.ireg[1]}, 16'h0010);
        chk(16'(n_irx[1]), 16'h0001);
        chk({12'h000, u_sab_cpu.last_page}, 16'h0003);
        wr(P1_CTRL_ADDR, 16'h0000);
        $display("test rx done");
    endtask

    // Two-word transmit buffer with a slow memory answer.
    task automatic t_tx;
        int b;
        b = n_bad;
        address_generator(0, 14'h0008, 14'h0002);
        u_sab_cpu.mem[8] = 16'h1234;
        u_sab_cpu.mem[9] = 16'h5678;
        ack_dly = 4'h3;
        wr(P0_CTRL_ADDR, 16'h0002);
        tx_free(0);
        wait_moves(1);
        chk(load_q.pop_front(), 16'h1234);
        chk(16'(n_itx[0]), 16'h0000);
        tx_free(0);
        wait_moves(1);
        chk(load_q.pop_front(), 16'h5678);
        chk(16'(n_itx[0]), 16'h0001);
        chk(16'(n_bad - b), 16'h0000);
        wr(P0_CTRL_ADDR, 16'h0000);
        $display("test tx done");
    endtask

    // Four requests at once, held off by DMA cycles and a long instruction.
    task automatic t_prio;
        int s;
        int b;
        int rs [4] = '{0, 1, 4, 5};
        logic [15:0] e [4] = '{16'h0000, 16'h0009, 16'h0026, 16'h002d};
        for (int k = 0; k < 4; k++) address_generator(rs[k], 14'(32 + 8 * k), 14'h0008);
        wr(P0_CTRL_ADDR, 16'h0017);
        wr(P1_CTRL_ADDR, 16'h0957);
        HOST_DMA_CYCLE = 1'b1;
        s = n_steal;
        b = sel_q.size();
        RX_WORD_VALID = 2'h3;
        TX_REG_FREE = 2'h3;
        cyc(1);
        RX_WORD_VALID = 2'h0;
        TX_REG_FREE = 2'h0;
        cyc(8);
        HOST_DMA_CYCLE = 1'b0;
        BYTE_DMA_CYCLE = 1'b1;
        cyc(8);
        chk(16'(n_steal - s), 16'h0000);
        BYTE_DMA_CYCLE = 1'b0;
        INSTR_DONE = 1'b0;
        cyc(8);
        chk(16'(n_steal - s), 16'h0000);
        INSTR_DONE = 1'b1;
        wait_moves(4);
        for (int k = 0; k < 4; k++) chk({10'h000, sel_q[b + k]}, e[k]);
        load_q.delete();
        wr(P0_CTRL_ADDR, 16'h0000);
        wr(P1_CTRL_ADDR, 16'h0000);
        $display("test prio done");
    endtask

    // Memory stalls: the queue fills and refuses, then drains in order.
    task automatic t_fill;
        int w;
        address_generator(1, 14'h0000, 14'h0020);
        wr(P1_CTRL_ADDR, 16'h0015);
        stall = 1'b1;
        w = u_sab_cpu.n_wr;
        for (int k = 0; k < 17; k++) begin
            rx_word(1, 16'(16'hb000 + k));
            cyc(7);
        end
        chk({2'h0, u_sab_cpu.ireg[1]}, 16'h0010);
        stall = 1'b0;
        for (int i = 0; i < 200 && u_sab_cpu.n_wr < w + 17; i++) cyc(1);
        cyc(4);
        chk(16'(u_sab_cpu.n_wr - w), 16'h0011);
        chk({2'h0, u_sab_cpu.ireg[1]}, 16'h0011);
        chk(u_sab_cpu.mem[16], 16'hb010);
        wr(P1_CTRL_ADDR, 16'h0000);
        $display("test fill done");
    endtask

    // Reboot drops the enables but keeps the selects.
    task automatic t_reboot;
        int k;
        wr(P0_CTRL_ADDR, 16'h0017);
        REBOOT = 1'b1;
        cyc(1);
        REBOOT = 1'b0;
        rd_chk(P0_CTRL_ADDR, 16'h0014);
        k = n_irx[0];
        rx_word(0, 16'h3333);
        cyc(4);
        chk(16'(n_irx[0] - k), 16'h0001);
        $display("test reboot done");
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Overlay page never changes mid-buffer.
    initial begin
        cyc(3);
        SRST = 1'b0;
        cyc(1);
        t_regs;
        t_plain;
        t_rx;
        t_tx;
        t_prio;
        t_fill;
        t_reboot;
        final_report;
    end

    // The tests need under 400 cycles; 5000 cycles means a hang.
    initial begin
        #20000;
        n_errors++;
        final_report;
    end
endmodule
